// ==== mac_csr_checker.sv ====
`timescale 1ns/1ps
module mac_csr_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // link signals
  input wire logic [mac_csr_pkg::ADDR_W-1:0] csr_addr,
  input wire logic csr_read,
  input wire logic csr_write,
  input wire logic [mac_csr_pkg::DATA_W-1:0] csr_rdata,
  input wire logic csr_ack,
  input wire logic st_valid,
  input wire logic st_ready,
  input wire mac_csr_pkg::stream_word_t st_word
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic in_frame;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_frame <= 1'b0;
    end else if (st_valid && st_ready) begin
      in_frame <= !st_word.eop;
    end
  end
  property p_ack_next; (csr_read || csr_write) && !csr_ack |=> csr_ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_cause; csr_ack |-> $past(csr_read || csr_write) && !$past(csr_ack); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_req_hold; (csr_read || csr_write) && !csr_ack |=> $stable(csr_addr) && $stable(csr_write); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  property p_one_kind; !(csr_read && csr_write); endproperty
  a_one_kind: assert property (p_one_kind) else $error("read and write together");
  property p_wr_zero; csr_ack && $past(csr_write) |-> csr_rdata == '0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write ack with data");
  // byte bits 7:4 set means no register lives there
  property p_undef_zero; csr_ack && $past(csr_read) && $past(csr_addr[5:2]) != 4'h0 |-> csr_rdata == '0; endproperty
  a_undef_zero: assert property (p_undef_zero) else $error("undefined offset not zero");
  property p_st_hold; st_valid && !st_ready |=> st_valid && $stable(st_word); endproperty
  a_st_hold: assert property (p_st_hold) else $error("stream word dropped while stalled");
  property p_st_order; st_valid && st_ready && in_frame |-> !st_word.sop; endproperty
  a_st_order: assert property (p_st_order) else $error("start inside a frame");
  c_read: cover property (csr_ack && $past(csr_read));
  c_write: cover property (csr_ack && $past(csr_write));
  c_eop: cover property (st_valid && st_ready && st_word.eop);
endmodule

// ==== mac_csr_dev.sv ====
`timescale 1ns/1ps
module mac_csr_dev #(
  parameter mac_csr_pkg::variant_t VARIANT = mac_csr_pkg::VAR_FULL
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // link from the host side
  mac_link_if.device link,
  // frame output towards the line
  output logic out_valid_o,
  input wire logic out_ready_i,
  output mac_csr_pkg::stream_word_t out_word_o,
  // configuration seen by the datapath
  output logic rx_path_off_o,
  output logic strip_fcs_o,
  output logic strip_pad_o
);
  logic [15:0] ofs;
  logic [4:0] sub;
  logic present;
  logic take;
  logic wr;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic rx_xfer_reg;
  logic [1:0] strip_reg;
  logic tx_xfer_reg;
  logic tx_off_reg;
  logic [31:0] pause_reg;
  logic [31:0] pfc_reg;
  logic [31:0] mac_lo_reg;
  logic [15:0] mac_hi_reg;
  logic [15:0] corr_reg;
  logic [31:0] good_reg;
  logic [31:0] err_reg;
  logic [31:0] inv_reg;
  logic stats_clr;
  logic in_frame_reg;
  logic [10:0] wcnt_reg;
  logic [10:0] etype_pos_reg;
  logic [1:0] tags_reg;
  logic is4_reg;
  logic is6_reg;
  logic udp_reg;
  logic ptp_reg;
  logic match_reg;
  logic [15:0] adj_reg;
  logic [10:0] udp_pos;
  logic [15:0] dest_word;
  logic acc;
  logic buf_in_ready;
  logic buf_empty;
  logic idle;
  logic match_now;
  logic len_ok;
  logic [11:0] len_bytes;
  logic good_inc;
  logic err_inc;
  logic inv_inc;
  mac_csr_pkg::stream_word_t w;
  mac_csr_pkg::stream_word_t o;

  function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

  // clear and event in one cycle: the event survives
  function automatic logic [31:0] cnt_next(input logic [31:0] c, input logic clr, input logic inc);
    logic [31:0] base;
    base = clr ? 32'h00000000 : c;
    return inc ? base + 32'h00000001 : base;
  endfunction

  // register bus
  assign ofs = {1'b0, link.csr_addr, 2'b00};
  assign sub = mac_csr_pkg::sub_index(ofs);
  always_comb begin
    case (VARIANT)
      mac_csr_pkg::VAR_RX_ONLY: present = sub < 5'(mac_csr_pkg::RX_SUB_N);
      mac_csr_pkg::VAR_TX_ONLY: present = sub >= 5'(mac_csr_pkg::RX_SUB_N);
      default: present = 1'b1;
    endcase
  end
  // absent ranges still answer, so a stray access cannot hang the bus
  assign take = (link.csr_read | link.csr_write) & ~ack_reg;
  assign idle = !in_frame_reg && buf_empty;
  assign wr = take && link.csr_write && present && (idle || mac_csr_pkg::is_live_reg(ofs));
  assign stats_clr = wr && ofs == mac_csr_pkg::TX_STATS_CLR_OFS;
  assign link.csr_ack = ack_reg;
  assign link.csr_rdata = rdata_reg;

  always_comb begin
    rdata_next = 32'h00000000;
    if (present) begin
      case (ofs)
        mac_csr_pkg::RX_XFER_CTRL_OFS: rdata_next = {31'h00000000, rx_xfer_reg};
        mac_csr_pkg::RX_XFER_STAT_OFS: rdata_next = {31'h00000000, rx_xfer_reg};
        mac_csr_pkg::RX_STRIP_OFS: rdata_next = {30'h00000000, strip_reg};
        mac_csr_pkg::TX_XFER_CTRL_OFS: rdata_next = {31'h00000000, tx_xfer_reg};
        mac_csr_pkg::TX_XFER_STAT_OFS: rdata_next = {31'h00000000, tx_off_reg};
        mac_csr_pkg::TX_PAUSE_OFS: rdata_next = pause_reg;
        mac_csr_pkg::TX_PFC_OFS: rdata_next = pfc_reg;
        mac_csr_pkg::MAC_ADDR_LO_OFS: rdata_next = mac_lo_reg;
        mac_csr_pkg::MAC_ADDR_HI_OFS: rdata_next = {16'h0000, mac_hi_reg};
        mac_csr_pkg::PTP_CORR_OFS: rdata_next = {16'h0000, corr_reg};
        mac_csr_pkg::STAT_GOOD_OFS: rdata_next = good_reg;
        mac_csr_pkg::STAT_ERR_OFS: rdata_next = err_reg;
        mac_csr_pkg::STAT_INV_OFS: rdata_next = inv_reg;
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= take;
      if (take) rdata_reg <= link.csr_read ? rdata_next : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_xfer_reg <= mac_csr_pkg::CTRL_RST[0];
      strip_reg <= mac_csr_pkg::RX_STRIP_RST[1:0];
      tx_xfer_reg <= mac_csr_pkg::CTRL_RST[0];
      pause_reg <= mac_csr_pkg::CTRL_RST;
      pfc_reg <= mac_csr_pkg::CTRL_RST;
      mac_lo_reg <= mac_csr_pkg::CTRL_RST;
      mac_hi_reg <= mac_csr_pkg::CTRL_RST[15:0];
      corr_reg <= mac_csr_pkg::CTRL_RST[15:0];
    end else if (wr) begin
      case (ofs)
        mac_csr_pkg::RX_XFER_CTRL_OFS: rx_xfer_reg <= link.csr_wdata[mac_csr_pkg::XFER_OFF_BIT];
        mac_csr_pkg::RX_STRIP_OFS: strip_reg <= link.csr_wdata[1:0];
        mac_csr_pkg::TX_XFER_CTRL_OFS: tx_xfer_reg <= link.csr_wdata[mac_csr_pkg::XFER_OFF_BIT];
        mac_csr_pkg::TX_PAUSE_OFS: pause_reg <= link.csr_wdata;
        mac_csr_pkg::TX_PFC_OFS: pfc_reg <= link.csr_wdata;
        mac_csr_pkg::MAC_ADDR_LO_OFS: mac_lo_reg <= link.csr_wdata;
        mac_csr_pkg::MAC_ADDR_HI_OFS: mac_hi_reg <= link.csr_wdata[15:0];
        mac_csr_pkg::PTP_CORR_OFS: corr_reg <= link.csr_wdata[15:0];
        default: ;
      endcase
    end
  end

  // pad stripping implies fcs stripping
  assign rx_path_off_o = rx_xfer_reg;
  assign strip_pad_o = strip_reg[mac_csr_pkg::STRIP_PAD_BIT];
  assign strip_fcs_o = strip_reg[mac_csr_pkg::STRIP_FCS_BIT] | strip_reg[mac_csr_pkg::STRIP_PAD_BIT];

  // frame parsing
  assign w = link.st_word;
  assign link.st_ready = tx_off_reg | buf_in_ready;
  assign acc = link.st_valid & link.st_ready;
  assign udp_pos = etype_pos_reg + 11'h001 + (is4_reg ? mac_csr_pkg::IPV4_HDR_WORDS : mac_csr_pkg::IPV6_HDR_WORDS);
  always_comb begin
    case (wcnt_reg)
      11'h000: dest_word = mac_hi_reg;
      11'h001: dest_word = mac_lo_reg[31:16];
      default: dest_word = mac_lo_reg[15:0];
    endcase
  end
  assign match_now = match_reg && (wcnt_reg > mac_csr_pkg::DEST_LAST_WORD || w.data == dest_word);
  assign len_bytes = {wcnt_reg + 11'h001, 1'b0};
  assign len_ok = len_bytes >= mac_csr_pkg::MIN_FRAME_BYTES && len_bytes <= mac_csr_pkg::MAX_FRAME_BYTES;
  assign good_inc = acc && !tx_off_reg && w.eop && wcnt_reg >= mac_csr_pkg::DEST_LAST_WORD && match_now;
  assign inv_inc = acc && !tx_off_reg && w.eop && !(wcnt_reg >= mac_csr_pkg::DEST_LAST_WORD && match_now);
  assign err_inc = good_inc && (w.err || !len_ok);

  always_comb begin
    o = w;
    if (is4_reg && udp_reg && ptp_reg && wcnt_reg == udp_pos + mac_csr_pkg::UDP_CSUM_WORD) begin
      o.data = 16'h0000;
    end
    if (is6_reg && udp_reg && ptp_reg && wcnt_reg == udp_pos + mac_csr_pkg::PTP_CORR_WORD) begin
      o.data = corr_reg;
    end
    if (is6_reg && udp_reg && ptp_reg && w.eop) begin
      o.data = oc_add(w.data, adj_reg);
    end
    if (inv_inc) o.err = 1'b1;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_frame_reg <= 1'b0;
      wcnt_reg <= '0;
      etype_pos_reg <= mac_csr_pkg::ETYPE_WORD;
      tags_reg <= '0;
      is4_reg <= 1'b0;
      is6_reg <= 1'b0;
      udp_reg <= 1'b0;
      ptp_reg <= 1'b0;
      match_reg <= 1'b1;
      adj_reg <= '0;
    end else if (acc) begin
      in_frame_reg <= !w.eop;
      match_reg <= w.eop ? 1'b1 : match_now;
      if (wcnt_reg != 11'h7FF) wcnt_reg <= wcnt_reg + 11'h001;
      if (wcnt_reg == etype_pos_reg) begin
        if ((w.data == mac_csr_pkg::ETH_VLAN || w.data == mac_csr_pkg::ETH_QINQ) && tags_reg != mac_csr_pkg::MAX_TAGS) begin
          etype_pos_reg <= etype_pos_reg + mac_csr_pkg::VLAN_SHIFT_WORDS;
          tags_reg <= tags_reg + 2'h1;
        end
        is4_reg <= w.data == mac_csr_pkg::ETH_IPV4;
        is6_reg <= w.data == mac_csr_pkg::ETH_IPV6;
      end
      if (is4_reg && wcnt_reg == etype_pos_reg + 11'h001 + mac_csr_pkg::IPV4_PROTO_WORD) begin
        udp_reg <= w.data[7:0] == mac_csr_pkg::IP_PROTO_UDP;
      end
      if (is6_reg && wcnt_reg == etype_pos_reg + 11'h001 + mac_csr_pkg::IPV6_NH_WORD) begin
        udp_reg <= w.data[15:8] == mac_csr_pkg::IP_PROTO_UDP;
      end
      if (udp_reg && wcnt_reg == udp_pos + mac_csr_pkg::UDP_DPORT_WORD) begin
        ptp_reg <= w.data == mac_csr_pkg::PTP_EVENT_PORT || w.data == mac_csr_pkg::PTP_GEN_PORT;
      end
      if (is6_reg && udp_reg && ptp_reg && wcnt_reg == udp_pos + mac_csr_pkg::PTP_CORR_WORD) begin
        adj_reg <= oc_add(w.data, ~corr_reg);
      end
      if (w.eop) begin
        wcnt_reg <= '0;
        etype_pos_reg <= mac_csr_pkg::ETYPE_WORD;
        tags_reg <= '0;
        is4_reg <= 1'b0;
        is6_reg <= 1'b0;
        udp_reg <= 1'b0;
        ptp_reg <= 1'b0;
        adj_reg <= '0;
      end
    end
  end

  // tx path enable takes effect only between frames, never cutting one; rx_path_off_o follows rx_xfer_reg at once
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_off_reg <= mac_csr_pkg::CTRL_RST[0];
    end else if (!in_frame_reg && !(acc && !w.eop)) begin
      tx_off_reg <= tx_xfer_reg;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      good_reg <= '0;
      err_reg <= '0;
      inv_reg <= '0;
    end else begin
      good_reg <= cnt_next(good_reg, stats_clr, good_inc && !err_inc);
      err_reg <= cnt_next(err_reg, stats_clr, err_inc);
      inv_reg <= cnt_next(inv_reg, stats_clr, inv_inc);
    end
  end

  stream_buf2 #(
    .WIDTH($bits(mac_csr_pkg::stream_word_t)),
    .DEPTH(mac_csr_pkg::BUF_DEPTH)
  ) out_buf (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(link.st_valid && !tx_off_reg),
    .in_ready_o(buf_in_ready),
    .in_data_i(o),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(out_word_o)
  );
  assign buf_empty = !out_valid_o;
endmodule

// ==== mac_csr_host.sv ====
`timescale 1ns/1ps
module mac_csr_host (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // link to the mac
  mac_link_if.host link,
  // register command port, byte offsets
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_write_i,
  input wire logic [15:0] cmd_addr_i,
  input wire logic [31:0] cmd_wdata_i,
  output logic rsp_valid_o,
  output logic [31:0] rsp_rdata_o,
  // client frame source
  input wire logic src_valid_i,
  output logic src_ready_o,
  input wire mac_csr_pkg::stream_word_t src_word_i,
  input wire logic src_ptp6_i
);
  typedef enum {H_IDLE, H_WAIT} hstate_t;
  hstate_t state_reg;
  logic [mac_csr_pkg::ADDR_W-1:0] addr_reg;
  logic wr_reg;
  logic [31:0] wdata_reg;
  logic in_frame_reg;
  logic trailer_reg;
  logic trailer_err_reg;
  logic src_acc;
  logic frame_idle;

  // config writes wait for a quiet link unless live
  assign frame_idle = !in_frame_reg && !trailer_reg;
  assign cmd_ready_o = (state_reg == H_IDLE) && (frame_idle || mac_csr_pkg::is_live_reg(cmd_addr_i));
  assign link.csr_addr = addr_reg;
  assign link.csr_read = (state_reg == H_WAIT) && !wr_reg;
  assign link.csr_write = (state_reg == H_WAIT) && wr_reg;
  assign link.csr_wdata = wdata_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= H_IDLE;
      addr_reg <= '0;
      wr_reg <= 1'b0;
      wdata_reg <= '0;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
    end else begin
      rsp_valid_o <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (cmd_valid_i && cmd_ready_o) begin
            addr_reg <= cmd_addr_i[mac_csr_pkg::ADDR_W+1:2];
            wr_reg <= cmd_write_i;
            wdata_reg <= cmd_wdata_i;
            state_reg <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (link.csr_ack) begin
            rsp_valid_o <= 1'b1;
            rsp_rdata_o <= link.csr_rdata;
            state_reg <= H_IDLE;
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  // ipv6 ptp frames get two extra bytes after the payload
  always_comb begin
    link.st_word = src_word_i;
    if (trailer_reg) begin
      link.st_word = '{data: '0, sop: 1'b0, eop: 1'b1, err: trailer_err_reg};
    end else if (src_ptp6_i) begin
      link.st_word.eop = 1'b0;
    end
  end
  assign link.st_valid = trailer_reg | src_valid_i;
  assign src_ready_o = !trailer_reg && link.st_ready;
  assign src_acc = src_valid_i && src_ready_o;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_frame_reg <= 1'b0;
      trailer_reg <= 1'b0;
      trailer_err_reg <= 1'b0;
    end else begin
      if (src_acc) begin
        in_frame_reg <= !src_word_i.eop;
        if (src_word_i.eop && src_ptp6_i) begin
          trailer_reg <= 1'b1;
          trailer_err_reg <= src_word_i.err;
        end
      end else if (trailer_reg && link.st_ready) begin
        trailer_reg <= 1'b0;
      end
    end
  end
endmodule

// ==== mac_csr_map_ptp_encap_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module mac_csr_map_ptp_encap_tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic cmd_write_i = 1'b0;
  logic [15:0] cmd_addr_i = 16'h0000;
  logic [31:0] cmd_wdata_i = 32'h00000000;
  logic src_valid_i = 1'b0;
  logic out_ready_i = 1'b0;
  logic src_ptp6_i = 1'b0;
  mac_csr_pkg::stream_word_t src_word_i = '0;
  mac_csr_pkg::stream_word_t out_word_o;
  logic cmd_ready_o, rsp_valid_o, src_ready_o, out_valid_o, rx_path_off_o, strip_fcs_o, strip_pad_o;
  logic [31:0] rsp_rdata_o, rd;
  logic [47:0] mac;
  int n_mismatch = 0;
  int compares = 0;
  int cnt[3] = '{0, 0, 0};
  mac_csr_pkg::stream_word_t seen_q[$], exp_q[$];
  mac_link_if link ();
  always #50 clk_i = ~clk_i;
  mac_csr_host u_mac_csr_host (.*);
  mac_csr_dev u_mac_csr_dev (.*);
  mac_csr_checker u_mac_csr_checker (.clk_i(clk_i), .resetn_i(resetn_i), .csr_addr(link.csr_addr),
    .csr_read(link.csr_read), .csr_write(link.csr_write), .csr_rdata(link.csr_rdata), .csr_ack(link.csr_ack),
    .st_valid(link.st_valid), .st_ready(link.st_ready), .st_word(link.st_word));
  // line side stalls at random so the buffer fills
  always @(negedge clk_i) out_ready_i <= ($urandom_range(3) != 0);
  always @(posedge clk_i) if (resetn_i && out_valid_o && out_ready_i) seen_q.push_back(out_word_o);
  // ones' complement sum, the way the udp checksum adds
  function automatic logic [15:0] oc(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic csr(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk_i);
    cmd_valid_i = 1'b1;
    cmd_write_i = wr;
    cmd_addr_i = a;
    cmd_wdata_i = d;
    #1;
    while (cmd_ready_o !== 1'b1 && n < 2000) begin @(negedge clk_i); #1; n++; end
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1 && n < 2000) begin @(negedge clk_i); n++; end
    if (n >= 2000) n_mismatch++;
    rd = rsp_rdata_o;
  endtask
  task automatic send(input logic [15:0] w[$], input logic ef);
    int n;
    for (int i = 0; i < w.size(); i++) begin
      @(negedge clk_i);
      src_valid_i = 1'b1;
      src_word_i = '{w[i], i == 0, i == w.size() - 1, ef && i == w.size() - 1};
      n = 0;
      #1;
      while (src_ready_o !== 1'b1 && n < 2000) begin @(negedge clk_i); #1; n++; end
      if (n >= 2000) n_mismatch++;
    end
    @(negedge clk_i);
    src_valid_i = 1'b0;
    // idle word inverted so a stray sample shows up
    src_word_i = ~src_word_i;
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (seen_q.size() < exp_q.size() && n < 3000) begin @(negedge clk_i); n++; end
    repeat (4) @(negedge clk_i);
    `CHK("out_count", exp_q.size(), seen_q.size())
    for (int i = 0; i < exp_q.size() && i < seen_q.size(); i++) `CHK("out_word", exp_q[i], seen_q[i])
    exp_q.delete();
    seen_q.delete();
  endtask
  // mode 0 plain, 1 foreign address, 2 errored, 3..5 ptp with 0..2 tags, 6 path off, 7 ptp over ipv6
  task automatic run_frame(input int nw, input int mode);
    logic [15:0] w[$];
    logic [47:0] dst;
    int t, k, cs;
    logic [15:0] cv;
    dst = (mode == 1) ? ~mac : mac;
    t = mode - 3;
    cs = -1;
    for (int i = 0; i < nw; i++) w.push_back(16'($urandom));
    w[0] = dst[47:32];
    w[1] = dst[31:16];
    w[2] = dst[15:0];
    w[6] = 16'h9000;
    if (mode inside {[3:5]}) begin
      k = 6 + 2 * t;
      if (t > 0) w[6] = (t == 2) ? mac_csr_pkg::ETH_QINQ : mac_csr_pkg::ETH_VLAN;
      if (t == 2) w[8] = mac_csr_pkg::ETH_VLAN;
      w[k] = mac_csr_pkg::ETH_IPV4;
      w[k + 1] = 16'h4500;
      w[k + 5] = {8'h40, mac_csr_pkg::IP_PROTO_UDP};
      w[k + 12] = mac_csr_pkg::PTP_EVENT_PORT;
      cs = k + 14;
    end
    if (mode == 7) begin
      w[6] = mac_csr_pkg::ETH_IPV6;
      w[10] = {mac_csr_pkg::IP_PROTO_UDP, 8'h40};
      w[28] = mac_csr_pkg::PTP_GEN_PORT;
      cs = 38;
    end
    cv = (mode == 7) ? mac[15:0] : 16'h0000;
    src_ptp6_i = (mode == 7);
    k = (mode == 1) ? 2 : (mode == 2 || nw * 2 < 64 || nw * 2 > 1518) ? 1 : 0;
    for (int i = 0; i < nw && mode != 6; i++)
      exp_q.push_back('{(i == cs) ? cv : w[i], i == 0, i == nw - 1 && mode != 7, i == nw - 1 && mode inside {1, 2}});
    // trailer absorbs old minus new correction
    if (mode == 7) exp_q.push_back('{oc(w[cs], ~cv), 1'b0, 1'b1, 1'b0});
    send(w, mode == 2);
    drain();
    if (mode != 6) cnt[k]++;
    for (int j = 0; j < 3; j++) begin
      csr(1'b0, mac_csr_pkg::STAT_GOOD_OFS + 16'(4 * j), 32'h0);
      `CHK("stat", 32'(cnt[j]), rd)
    end
  endtask
  initial begin
    void'($urandom(75813));
    mac = {16'($urandom), $urandom};
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    resetn_i = 1'b1;
    csr(1'b0, mac_csr_pkg::RX_STRIP_OFS, 32'h0);
    `CHK("strip_reset", mac_csr_pkg::RX_STRIP_RST, rd)
    for (int i = 0; i < mac_csr_pkg::SUB_N; i++) begin
      csr(1'b1, mac_csr_pkg::SUB_BASE[i] + 16'h0040, $urandom);
      csr(1'b0, mac_csr_pkg::SUB_BASE[i] + 16'h0040, 32'h0);
      `CHK("undef", 32'h0, rd)
    end
    for (int v = 0; v < 4; v++) begin
      csr(1'b1, mac_csr_pkg::RX_STRIP_OFS, 32'(v));
      csr(1'b0, mac_csr_pkg::RX_STRIP_OFS, 32'h0);
      `CHK("strip_rd", 2'(v), rd[1:0])
      `CHK("strip_fcs", v != 0, strip_fcs_o)
      `CHK("strip_pad", v[1], strip_pad_o)
    end
    csr(1'b1, mac_csr_pkg::PTP_CORR_OFS, {16'h0, mac[15:0]});
    csr(1'b0, mac_csr_pkg::PTP_CORR_OFS, 32'h0);
    `CHK("ptp_corr", mac[15:0], rd[15:0])
    csr(1'b1, mac_csr_pkg::MAC_ADDR_LO_OFS, mac[31:0]);
    csr(1'b1, mac_csr_pkg::MAC_ADDR_HI_OFS, {16'h0, mac[47:32]});
    csr(1'b1, mac_csr_pkg::TX_STATS_CLR_OFS, 32'h1);
    run_frame(32, 0);
    run_frame(31, 0);
    run_frame(759, 0);
    run_frame(760, 0);
    for (int m = 1; m < 6; m++) run_frame(40, m);
    run_frame(40, 7);
    repeat (6) run_frame(32 + $urandom_range(20), $urandom_range(5));
    csr(1'b1, mac_csr_pkg::TX_XFER_CTRL_OFS, 32'h1);
    csr(1'b0, mac_csr_pkg::TX_XFER_STAT_OFS, 32'h0);
    `CHK("tx_off", 1'b1, rd[0])
    run_frame(32, 6);
    csr(1'b1, mac_csr_pkg::TX_XFER_CTRL_OFS, 32'h0);
    // live control write lands mid-frame
    fork
      run_frame(300, 0);
      begin
        repeat (20) @(negedge clk_i);
        csr(1'b1, mac_csr_pkg::RX_XFER_CTRL_OFS, 32'h1);
      end
    join
    `CHK("rx_off", 1'b1, rx_path_off_o)
    csr(1'b0, mac_csr_pkg::RX_XFER_STAT_OFS, 32'h0);
    `CHK("rx_stat", 1'b1, rd[0])
    complete_run();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    complete_run();
  end
endmodule

// ==== mac_csr_pkg.sv ====
// Operation
// - good: clean and legal length; error otherwise
// - frames not for us invalid, discarded; code forwards them with err set on the last word
// - IPv4 UDP PTP: write checksum as zero
// - client appends two bytes after IPv6 payload
// - fix IPv6 trailer so checksum holds
// - VLAN tags shift fields 4 or 8 octets
// - rx-only: only 0x000 to 0x3FFF present
// - tx-only: only 0x4000 to 0x7FFF present
// - host touches only present ranges; code passes any offset through, and absent ranges ack with zero data
// - decode receive sub-block byte ranges
// - decode transmit sub-block byte ranges
// - host addresses words: byte offset / 4
// - host avoids config writes during traffic
// - live registers writable during traffic
// - strip bit0 FCS, bit1 pad+FCS wins
package mac_csr_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;
  localparam int BUF_DEPTH = 2;
  localparam logic [15:0] RX_XFER_CTRL_OFS = 16'h0000;
  localparam logic [15:0] RX_XFER_STAT_OFS = 16'h0004;
  localparam logic [15:0] RX_STRIP_OFS = 16'h0100;
  localparam logic [15:0] RX_STATS_CLR_OFS = 16'h3000;
  localparam logic [15:0] TX_SPACE_BASE = 16'h4000;
  localparam logic [15:0] TX_XFER_CTRL_OFS = 16'h4000;
  localparam logic [15:0] TX_XFER_STAT_OFS = 16'h4004;
  localparam logic [15:0] TX_PAUSE_OFS = 16'h4500;
  localparam logic [15:0] TX_PFC_OFS = 16'h4600;
  localparam logic [15:0] MAC_ADDR_LO_OFS = 16'h4800;
  localparam logic [15:0] MAC_ADDR_HI_OFS = 16'h4804;
  localparam logic [15:0] PTP_CORR_OFS = 16'h6000;
  localparam logic [15:0] TX_STATS_CLR_OFS = 16'h7000;
  localparam logic [15:0] STAT_GOOD_OFS = 16'h7004;
  localparam logic [15:0] STAT_ERR_OFS = 16'h7008;
  localparam logic [15:0] STAT_INV_OFS = 16'h700C;
  localparam logic [31:0] RX_STRIP_RST = 32'h00000001;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam int XFER_OFF_BIT = 0;
  localparam int STRIP_FCS_BIT = 0;
  localparam int STRIP_PAD_BIT = 1;
  // sub-block bases; a range runs to the next base
  localparam int SUB_N = 19;
  localparam int RX_SUB_N = 8;
  localparam logic [15:0] SUB_BASE [SUB_N] = '{
    16'h0000, 16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h0500, 16'h2000, 16'h3000,
    16'h4000, 16'h4100, 16'h4200, 16'h4300, 16'h4400, 16'h4480, 16'h4500, 16'h4600,
    16'h4800, 16'h6000, 16'h7000};
  localparam logic [15:0] ETH_VLAN = 16'h8100;
  localparam logic [15:0] ETH_QINQ = 16'h88A8;
  localparam logic [15:0] ETH_IPV4 = 16'h0800;
  localparam logic [15:0] ETH_IPV6 = 16'h86DD;
  localparam logic [7:0] IP_PROTO_UDP = 8'h11;
  localparam logic [15:0] PTP_EVENT_PORT = 16'h013F;
  localparam logic [15:0] PTP_GEN_PORT = 16'h0140;
  localparam logic [10:0] ETYPE_WORD = 11'h006;
  localparam logic [10:0] VLAN_SHIFT_WORDS = 11'h002;
  localparam logic [1:0] MAX_TAGS = 2'h2;
  localparam logic [10:0] IPV4_PROTO_WORD = 11'h004;
  localparam logic [10:0] IPV4_HDR_WORDS = 11'h00A;
  localparam logic [10:0] IPV6_NH_WORD = 11'h003;
  localparam logic [10:0] IPV6_HDR_WORDS = 11'h014;
  localparam logic [10:0] UDP_DPORT_WORD = 11'h001;
  localparam logic [10:0] UDP_CSUM_WORD = 11'h003;
  localparam logic [10:0] PTP_CORR_WORD = 11'h00B;
  localparam logic [10:0] DEST_LAST_WORD = 11'h002;
  localparam logic [11:0] MIN_FRAME_BYTES = 12'h040;
  localparam logic [11:0] MAX_FRAME_BYTES = 12'h5EE;

  typedef enum {VAR_FULL, VAR_RX_ONLY, VAR_TX_ONLY} variant_t;
  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic sop;
    logic eop;
    logic err;
  } stream_word_t;

  function automatic logic [4:0] sub_index(input logic [15:0] ofs);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 0; i < SUB_N; i++) begin
      if (ofs >= SUB_BASE[i]) idx = 5'(i);
    end
    return idx;
  endfunction

  function automatic logic is_live_reg(input logic [15:0] ofs);
    return ofs == RX_XFER_CTRL_OFS || ofs == TX_XFER_CTRL_OFS || ofs == TX_PAUSE_OFS ||
      ofs == RX_STATS_CLR_OFS || ofs == TX_STATS_CLR_OFS || ofs == TX_PFC_OFS ||
      ofs == PTP_CORR_OFS;
  endfunction
endpackage

// ==== mac_link_if.sv ====
`timescale 1ns/1ps
interface mac_link_if;
  logic [mac_csr_pkg::ADDR_W-1:0] csr_addr;
  logic csr_read;
  logic csr_write;
  logic [mac_csr_pkg::DATA_W-1:0] csr_wdata;
  logic [mac_csr_pkg::DATA_W-1:0] csr_rdata;
  logic csr_ack;
  logic st_valid;
  logic st_ready;
  mac_csr_pkg::stream_word_t st_word;
  modport device (
    input csr_addr, csr_read, csr_write, csr_wdata, st_valid, st_word,
    output csr_rdata, csr_ack, st_ready
  );
  modport host (
    output csr_addr, csr_read, csr_write, csr_wdata, st_valid, st_word,
    input csr_rdata, csr_ack, st_ready
  );
endinterface

// ==== stream_buf2.sv ====
`timescale 1ns/1ps
module stream_buf2 #(
  parameter int WIDTH = $bits(mac_csr_pkg::stream_word_t),
  parameter int DEPTH = mac_csr_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp_reg;
  logic [PW-1:0] rp_reg;
  logic [PW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready_o = cnt_reg != (PW+1)'(DEPTH);
  assign out_valid_o = cnt_reg != '0;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rp_reg];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wp_reg <= (wp_reg == PW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      if (pop) rp_reg <= (rp_reg == PW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule
